// [verif/usrb_top_tb.sv]
`timescale 1ns/100ps
module usrb_top_tb;
  import usrb_pkg::*;
  logic        core_clk, nrst, psel, penable, pwrite, pready, pslverr, ovr, irq, gie, rxd, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  int          miscompares = 0;
  int          n_tests = 0;
  int          cyc = 0;

  usrb_top dut (.core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_input_pin(rxd), .rx_pin_override(ovr), .global_irq_enable(gie), .rx_complete_irq(irq));
  usrb_tx_model m (.core_clk(core_clk), .line(rxd));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // Whole run needs about 3300 cycles
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      miscompares++;
      print_verdict;
    end
  end
  // ====================
  // Tasks
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, e);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("Error at %0t: got %h, expected %h", $time, g, e);
    end
  endtask
  task automatic cb(input logic g, e);
    chk(32'(g), 32'(e));
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(r, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic tx(input logic [8:0] d, input int nb, input logic pon, pb, sb);
    m.send(d, nb, pon, pb, sb, 16);
    repeat (4) @(posedge core_clk);
  endtask
  task automatic done(input string s);
    $display("Test %s finished", s);
  endtask
  // ====================
  // Tests
  initial begin
    {nrst, psel, penable, pwrite, gie} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    rc(OFF_STATUS, 32'h0000_0000);
    rc(OFF_CTRL_B, 32'h0000_0000);
    rc(OFF_CTRL_C, 32'h0000_0006);
    rc(OFF_DATA, 32'h0000_0000);
    rc(8'h14, 32'h0000_0000);
    cb(err, 1'b1);
    cb(ovr, 1'b0);
    done("reset");
    wr(OFF_CTRL_B, 32'h0000_0090);
    cb(ovr, 1'b1);
    tx(9'h0A5, 8, 1'b0, 1'b0, 1'b1);
    rc(OFF_STATUS, 32'h0000_0080);
    cb(irq, 1'b0);
    gie <= 1'b1;
    @(posedge core_clk);
    cb(irq, 1'b1);
    rc(OFF_DATA, 32'h0000_00A5);
    cb(irq, 1'b0);
    rc(OFF_STATUS, 32'h0000_0000);
    done("basic");
    wr(OFF_CTRL_C, 32'h0000_000E);
    tx(9'h03C, 8, 1'b0, 1'b0, 1'b0);
    rc(OFF_STATUS, 32'h0000_0090);
    wr(OFF_STATUS, 32'h0000_0000);
    rc(OFF_STATUS, 32'h0000_0090);
    rc(OFF_DATA, 32'h0000_003C);
    rc(OFF_STATUS, 32'h0000_0000);
    done("frame");
    wr(OFF_CTRL_C, 32'h0000_0026);
    tx(9'h003, 8, 1'b1, 1'b0, 1'b1);
    tx(9'h001, 8, 1'b1, 1'b0, 1'b1);
    rc(OFF_STATUS, 32'h0000_0080);
    rc(OFF_DATA, 32'h0000_0003);
    rc(OFF_STATUS, 32'h0000_0084);
    rc(OFF_DATA, 32'h0000_0001);
    wr(OFF_CTRL_C, 32'h0000_0036);
    tx(9'h001, 8, 1'b1, 1'b0, 1'b1);
    rc(OFF_STATUS, 32'h0000_0080);
    rc(OFF_DATA, 32'h0000_0001);
    tx(9'h001, 8, 1'b1, 1'b1, 1'b1);
    wr(OFF_CTRL_C, 32'h0000_0006);
    rc(OFF_STATUS, 32'h0000_0080);
    rc(OFF_DATA, 32'h0000_0001);
    done("parity");
    wr(OFF_CTRL_B, 32'h0000_0094);
    tx(9'h1A5, 9, 1'b0, 1'b0, 1'b1);
    rc(OFF_CTRL_B, 32'h0000_0096);
    rc(OFF_DATA, 32'h0000_00A5);
    rc(OFF_CTRL_B, 32'h0000_0094);
    wr(OFF_CTRL_B, 32'h0000_0090);
    wr(OFF_CTRL_C, 32'h0000_0000);
    tx(9'h015, 5, 1'b0, 1'b0, 1'b1);
    rc(OFF_DATA, 32'h0000_0015);
    done("sizes");
    wr(OFF_CTRL_C, 32'h0000_0006);
    for (int i = 1; i < 5; i++) tx(9'(i * 17), 8, 1'b0, 1'b0, 1'b1);
    rc(OFF_STATUS, 32'h0000_0080);
    rc(OFF_DATA, 32'h0000_0011);
    rc(OFF_DATA, 32'h0000_0022);
    rc(OFF_STATUS, 32'h0000_0088);
    rc(OFF_DATA, 32'h0000_0044);
    tx(9'h055, 8, 1'b0, 1'b0, 1'b1);
    rc(OFF_STATUS, 32'h0000_0080);
    rc(OFF_DATA, 32'h0000_0055);
    rc(OFF_STATUS, 32'h0000_0000);
    done("overrun");
    m.spike(3);
    repeat (200) @(posedge core_clk);
    rc(OFF_STATUS, 32'h0000_0000);
    done("noise");
    m.send_glitch(8'h5A, 16, 8);
    repeat (4) @(posedge core_clk);
    rc(OFF_DATA, 32'h0000_005A);
    done("glitch");
    tx(9'h066, 8, 1'b0, 1'b0, 1'b1);
    fork
      m.send(9'h077, 8, 1'b0, 1'b0, 1'b1, 16);
      begin
        repeat (60) @(posedge core_clk);
        wr(OFF_CTRL_B, 32'h0000_0080);
      end
    join
    cb(ovr, 1'b0);
    rc(OFF_STATUS, 32'h0000_0000);
    cb(irq, 1'b0);
    wr(OFF_CTRL_B, 32'h0000_0090);
    repeat (200) @(posedge core_clk);
    rc(OFF_STATUS, 32'h0000_0000);
    done("disable");
    wr(OFF_STATUS, 32'h0000_0002);
    m.send(9'h0C3, 8, 1'b0, 1'b0, 1'b1, 8);
    repeat (4) @(posedge core_clk);
    rc(OFF_STATUS, 32'h0000_0082);
    rc(OFF_DATA, 32'h0000_00C3);
    done("double");
    print_verdict;
  end
endmodule

// [verif/usrb_tx_model.sv]
`timescale 1ns/100ps
module usrb_tx_model (
  // Clock
  input  wire logic core_clk,
  // Serial line, idles high
  output logic      line
);
  initial line = 1'b1;
  // ====================
  // Frames
  task automatic put(input logic b, input int spb);
    line <= b;
    repeat (spb) @(posedge core_clk);
  endtask
  // LSB first; a low stop value forces a frame error
  task automatic send(input logic [8:0] d, input int nb, input logic pon, pb, sb, input int spb);
    put(1'b0, spb);
    for (int i = 0; i < nb; i++) put(d[i], spb);
    if (pon) put(pb, spb);
    put(sb, spb);
    line <= 1'b1;
    // One idle cycle so the next start is a fresh edge
    @(posedge core_clk);
  endtask
  task automatic spike(input int n);
    put(1'b0, n);
    line <= 1'b1;
    @(posedge core_clk);
  endtask
  // 8N1 with a one-clock flip at offset g of every data bit; the vote must hide it
  task automatic send_glitch(input logic [7:0] d, input int spb, input int g);
    put(1'b0, spb);
    for (int i = 0; i < 8; i++) begin
      put(d[i], g);
      put(!d[i], 1);
      put(d[i], spb - g - 1);
    end
    put(1'b1, spb);
    line <= 1'b1;
    @(posedge core_clk);
  endtask
endmodule

// [verilog/usrb_pkg.sv]
// Behaviour
// - Ninth bit and error flags are stored per entry; a data read advances them.
// - Receive complete reads one while unread data is buffered, zero when empty.
// - Clearing receiver enable flushes the buffer and forces receive complete low.
// - Receive interrupt is asserted while enabled, globally enabled and receive complete set.
// - Writes to the status register cannot change the frame, overrun or parity error flags.
// - The error flags never raise an interrupt request.
// - Frame error is one when the first stop bit sampled as zero.
// - Only the first stop bit is checked; stop-bit count setting is ignored.
// - Overrun when buffer holds two, a third waits, and a start bit arrives.
// - Overrun clears when a frame moves from the shift register into the buffer.
// - With parity checking off the parity error flag reads zero.
// - Parity check runs only with the upper mode bit; lower bit picks odd or even.
// - Checker compares computed data parity with the received bit, stores the result.
// - Parity error set only if wrong and checking was on at arrival, until read.
// - Disabling is immediate: frame in progress dropped, pin returns to port function.
// - A data read frees its buffer slot at once for a new character.
// - Each bit is sampled several times and low-pass filtered.
// - After the first stop bit the frame moves to the buffer; second stop ignored.
// - For sizes below eight bits the unused upper data bits read as zero.
// - Start bit accepted by majority of samples 8,9,10 or 4,5,6, else noise.
// - Sampling is 16 per bit normal, 8 double speed; bit is centre-sample majority.
package usrb_pkg;

  // ==========================================================
  // Register map
  localparam int unsigned ADDR_W      = 8;
  localparam logic [7:0]  OFF_STATUS  = 8'h00;
  localparam logic [7:0]  OFF_CTRL_B  = 8'h04;
  localparam logic [7:0]  OFF_CTRL_C  = 8'h08;
  localparam logic [7:0]  OFF_DATA    = 8'h0C;
  localparam logic [7:0]  OFF_BAUD    = 8'h10;

  // ==========================================================
  // Field positions
  localparam int unsigned ST_RXC      = 7;
  localparam int unsigned ST_FE       = 4;
  localparam int unsigned ST_DOR      = 3;
  localparam int unsigned ST_PE       = 2;
  localparam int unsigned ST_DS       = 1;
  localparam int unsigned CB_RXCIE    = 7;
  localparam int unsigned CB_RXEN     = 4;
  localparam int unsigned CB_CS2      = 2;
  localparam int unsigned CB_RX9      = 1;
  localparam int unsigned CC_PM1      = 5;
  localparam int unsigned CC_PM0      = 4;
  localparam int unsigned CC_STOP     = 3;
  localparam int unsigned CC_CS_LO    = 1;

  // ==========================================================
  // Reset values and counts
  localparam logic [2:0]  CS_RST      = 3'h3;
  localparam logic [2:0]  CS_NINE     = 3'h7;
  localparam logic [15:0] BAUD_RST    = 16'h0000;
  localparam logic [4:0]  SPB_NORMAL  = 5'h10;
  localparam logic [4:0]  SPB_DOUBLE  = 5'h08;
  localparam logic [4:0]  VOTE_NORMAL = 5'h08;
  localparam logic [4:0]  VOTE_DOUBLE = 5'h04;
  localparam logic [3:0]  BITS_MIN    = 4'h5;
  localparam logic [3:0]  BITS_BYTE   = 4'h8;
  localparam logic [3:0]  BITS_NINE   = 4'h9;

  // ==========================================================
  // Types
  typedef struct packed {
    logic [8:0] data;
    logic       parity_bit;
    logic       stop_bit;
  } usrb_frame_type;

  typedef struct packed {
    logic       ninth;
    logic       fe;
    logic       dor;
    logic       pe;
    logic [7:0] data;
  } usrb_entry_type;

  typedef enum logic [4:0] {
    RXS_IDLE  = 5'h01,
    RXS_START = 5'h02,
    RXS_DATA  = 5'h04,
    RXS_PAR   = 5'h08,
    RXS_STOP  = 5'h10
  } usrb_rx_state_type;

endpackage

// [verilog/usrb_rx_frame.sv]
`timescale 1ns/100ps
module usrb_rx_frame (
  // Clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    nrst,
  // Configuration
  input  wire logic                    enable,
  input  wire logic                    double_speed,
  input  wire logic                    parity_en,
  input  wire logic [3:0]              nbits,
  // Sampling
  input  wire logic                    sample_tick,
  input  wire logic                    rx_in,
  // Frame out
  output logic                         start_seen,
  output logic                         frame_done,
  output usrb_pkg::usrb_frame_type     frame
);
  import usrb_pkg::*;

  usrb_rx_state_type state;
  logic [4:0]        cnt;
  logic [3:0]        bit_idx;
  logic [1:0]        samp;
  logic              prev_rx;
  logic [4:0]        spb;
  logic [4:0]        v_first;
  logic [4:0]        v_last;
  logic              vote;
  logic              at_vote;
  logic              at_end;

  function automatic logic maj3(input logic a, input logic b, input logic c);
    maj3 = (a & b) | (a & c) | (b & c);
  endfunction

  // ==========================================================
  // Sample position
  assign spb     = double_speed ? SPB_DOUBLE : SPB_NORMAL;
  assign v_first = double_speed ? VOTE_DOUBLE : VOTE_NORMAL;
  assign v_last  = v_first + 5'h02;
  assign vote    = maj3(samp[1], samp[0], rx_in);
  assign at_vote = sample_tick && (state != RXS_IDLE) && (cnt == v_last);
  assign at_end  = sample_tick && (cnt == spb);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      prev_rx <= 1'b1;
      samp    <= 2'h3;
    end else if (sample_tick) begin
      prev_rx <= rx_in;
      samp    <= {samp[0], rx_in};
    end
  end

  // Edge sample is sample 1, so the next tick is sample 2
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 5'h02;
    end else if (sample_tick) begin
      if (state == RXS_IDLE) begin
        cnt <= 5'h02;
      end else if (cnt == spb) begin
        cnt <= 5'h01;
      end else begin
        cnt <= cnt + 5'h01;
      end
    end
  end

  // ==========================================================
  // Frame sequencing
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state <= RXS_IDLE;
    end else if (!enable) begin
      state <= RXS_IDLE;
    end else if (sample_tick) begin
      unique case (state)
        RXS_IDLE: begin
          if (prev_rx && !rx_in) begin
            state <= RXS_START;
          end
        end
        RXS_START: begin
          if (at_vote && vote) begin
            state <= RXS_IDLE;
          end else if (at_end) begin
            state <= RXS_DATA;
          end
        end
        RXS_DATA: begin
          if (at_end && (bit_idx == nbits - 4'h1)) begin
            state <= parity_en ? RXS_PAR : RXS_STOP;
          end
        end
        RXS_PAR: begin
          if (at_end) begin
            state <= RXS_STOP;
          end
        end
        RXS_STOP: begin
          // Leaving at the vote lets the next start bit follow early
          if (at_vote) begin
            state <= RXS_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      bit_idx <= 4'h0;
    end else if (state != RXS_DATA) begin
      bit_idx <= 4'h0;
    end else if (at_end) begin
      bit_idx <= bit_idx + 4'h1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      frame      <= '0;
      frame_done <= 1'b0;
      start_seen <= 1'b0;
    end else begin
      frame_done <= enable && at_vote && (state == RXS_STOP);
      start_seen <= enable && at_vote && (state == RXS_START) && !vote;
      if (at_vote && (state == RXS_START)) begin
        frame.data <= 9'h000;
      end
      if (at_vote && (state == RXS_DATA)) begin
        frame.data[bit_idx] <= vote;
      end
      if (at_vote && (state == RXS_PAR)) begin
        frame.parity_bit <= vote;
      end
      if (at_vote && (state == RXS_STOP)) begin
        frame.stop_bit <= vote;
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_noise_reject: assert property (
    enable && at_vote && state == RXS_START && vote |=> state == RXS_IDLE && !start_seen)
    else $error("Noise start not rejected");
  a_disable_idle: assert property (
    !enable |=> state == RXS_IDLE ##1 !frame_done)
    else $error("Receiver busy while disabled");

endmodule

// [verilog/usrb_top.sv]
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
module usrb_top (
  // Clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        nrst,
  // APB slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [usrb_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // Serial line
  input  wire logic                        serial_input_pin,
  output logic                             rx_pin_override,
  // Interrupt
  input  wire logic                        global_irq_enable,
  output logic                             rx_complete_irq
);
  import usrb_pkg::*;

  // ==========================================================
  // Configuration registers
  logic        rx_complete_irq_enable;
  logic        rx_enable;
  logic        parity_check_enable;
  logic        parity_odd_select;
  logic        stop_bit_count_select;
  logic        double_speed_select;
  logic [2:0]  char_size_field;
  logic [15:0] baud_div;
  logic [3:0]  nbits;
  logic        nine;

  // ==========================================================
  // Bus decode
  logic        setup;
  logic        access;
  logic        addr_ok;
  logic        wr;
  logic        rd_armed;
  logic        rd_pop;

  assign setup   = psel && !penable;
  assign access  = psel && penable;
  assign addr_ok = (paddr == OFF_STATUS) || (paddr == OFF_CTRL_B) || (paddr == OFF_CTRL_C) ||
                   (paddr == OFF_DATA) || (paddr == OFF_BAUD);
  assign wr      = access && pwrite && addr_ok;
  assign pready  = 1'b1;
  assign pslverr = access && !addr_ok;
  // Pop only what the setup cycle captured, so a late arrival is never skipped
  assign rd_pop  = access && !pwrite && (paddr == OFF_DATA) && rd_armed;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rx_complete_irq_enable <= 1'b0;
      rx_enable              <= 1'b0;
      parity_check_enable    <= 1'b0;
      parity_odd_select      <= 1'b0;
      stop_bit_count_select  <= 1'b0;
      double_speed_select    <= 1'b0;
      char_size_field        <= CS_RST;
      baud_div               <= BAUD_RST;
    end else if (wr) begin
      unique case (paddr)
        OFF_STATUS: begin
          // Error flag positions are not storage and ignore the write
          double_speed_select <= pwdata[ST_DS];
        end
        OFF_CTRL_B: begin
          rx_complete_irq_enable <= pwdata[CB_RXCIE];
          rx_enable              <= pwdata[CB_RXEN];
          char_size_field[2]     <= pwdata[CB_CS2];
        end
        OFF_CTRL_C: begin
          parity_check_enable    <= pwdata[CC_PM1];
          parity_odd_select      <= pwdata[CC_PM0];
          stop_bit_count_select  <= pwdata[CC_STOP];
          char_size_field[1:0]   <= pwdata[CC_CS_LO +: 2];
        end
        OFF_BAUD: begin
          baud_div <= pwdata[15:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Reserved size codes fall back to eight bits
  assign nine  = (char_size_field == CS_NINE);
  assign nbits = nine ? BITS_NINE :
                 (!char_size_field[2] ? BITS_MIN + {2'b00, char_size_field[1:0]} : BITS_BYTE);

  // ==========================================================
  // Sample clock and pin synchroniser
  logic [15:0] div_cnt;
  logic        sample_tick;
  logic        pin_meta;
  logic        pin_sync;

  assign sample_tick = rx_enable && (div_cnt == baud_div);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      div_cnt <= 16'h0000;
    end else if (!rx_enable || sample_tick) begin
      div_cnt <= 16'h0000;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pin_meta <= 1'b1;
      pin_sync <= 1'b1;
    end else begin
      pin_meta <= serial_input_pin;
      pin_sync <= pin_meta;
    end
  end

  assign rx_pin_override = rx_enable;

  // ==========================================================
  // Frame receiver
  logic           start_seen;
  logic           frame_done;
  usrb_frame_type frame;

  usrb_rx_frame u_frame (
    .core_clk     (core_clk),
    .nrst         (nrst),
    .enable       (rx_enable),
    .double_speed (double_speed_select),
    .parity_en    (parity_check_enable),
    .nbits        (nbits),
    .sample_tick  (sample_tick),
    .rx_in        (pin_sync),
    .start_seen   (start_seen),
    .frame_done   (frame_done),
    .frame        (frame)
  );

  // ==========================================================
  // Entry built from a finished frame
  usrb_entry_type new_e;
  logic [8:0]     used;

  always_comb begin
    used        = frame.data & (nine ? 9'h1FF : {1'b0, 8'(~(8'hFF << nbits[2:0]))});
    if (nbits == BITS_BYTE) begin
      used      = {1'b0, frame.data[7:0]};
    end
    new_e.data  = used[7:0];
    new_e.ninth = used[8];
    new_e.fe    = !frame.stop_bit;
    new_e.dor   = 1'b0;
    new_e.pe    = parity_check_enable && ((^used) ^ frame.parity_bit ^ parity_odd_select);
  end

  // ==========================================================
  // Two-entry buffer with one character waiting in the shift register
  usrb_entry_type buf_mem [2];
  usrb_entry_type hold;
  usrb_entry_type head;
  usrb_entry_type push_e;
  logic           hold_valid;
  logic           rd_ptr;
  logic [1:0]     count;
  logic           dor_pend;
  logic           room;
  logic           take_hold;
  logic           take_new;
  logic           push;
  logic           ovr_start;

  assign room      = (count != 2'h2) || rd_pop;
  assign take_hold = hold_valid && room;
  assign take_new  = frame_done && !hold_valid && room;
  assign push      = take_hold || take_new;
  assign ovr_start = start_seen && (count == 2'h2) && hold_valid && !rd_pop;
  assign head      = buf_mem[rd_ptr];

  always_comb begin
    push_e     = take_hold ? hold : new_e;
    push_e.dor = dor_pend;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 2; i++) begin
        buf_mem[i] <= '0;
      end
    end else if (push) begin
      buf_mem[rd_ptr ^ count[0]] <= push_e;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      count  <= 2'h0;
      rd_ptr <= 1'b0;
    end else if (!rx_enable) begin
      count  <= 2'h0;
      rd_ptr <= 1'b0;
    end else begin
      count  <= count + {1'b0, push} - {1'b0, rd_pop};
      rd_ptr <= rd_ptr ^ rd_pop;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      hold_valid <= 1'b0;
      hold       <= '0;
    end else if (!rx_enable || ovr_start) begin
      hold_valid <= 1'b0;
    end else if (frame_done && !take_new) begin
      hold_valid <= 1'b1;
      hold       <= new_e;
    end else if (take_hold) begin
      hold_valid <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dor_pend <= 1'b0;
    end else if (!rx_enable) begin
      dor_pend <= 1'b0;
    end else if (ovr_start) begin
      dor_pend <= 1'b1;
    end else if (push) begin
      dor_pend <= 1'b0;
    end
  end

  // ==========================================================
  // Status view and read data
  logic rx_complete_flag;
  logic frame_error_flag;
  logic overrun_flag;
  logic parity_error_flag;
  logic rx_ninth_bit;

  assign rx_complete_flag  = (count != 2'h0);
  assign frame_error_flag  = rx_complete_flag && head.fe;
  assign overrun_flag      = rx_complete_flag && head.dor;
  assign parity_error_flag = rx_complete_flag && head.pe && parity_check_enable;
  assign rx_ninth_bit      = rx_complete_flag && head.ninth;
  // Error flags feed no request
  assign rx_complete_irq   = rx_complete_irq_enable && global_irq_enable && rx_complete_flag;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      prdata   <= 32'h0000_0000;
      rd_armed <= 1'b0;
    end else if (setup) begin
      rd_armed <= !pwrite && (paddr == OFF_DATA) && rx_complete_flag;
      prdata   <= 32'h0000_0000;
      if (!pwrite) begin
        unique case (paddr)
          OFF_STATUS: begin
            prdata[ST_RXC] <= rx_complete_flag;
            prdata[ST_FE]  <= frame_error_flag;
            prdata[ST_DOR] <= overrun_flag;
            prdata[ST_PE]  <= parity_error_flag;
            prdata[ST_DS]  <= double_speed_select;
          end
          OFF_CTRL_B: begin
            prdata[CB_RXCIE] <= rx_complete_irq_enable;
            prdata[CB_RXEN]  <= rx_enable;
            prdata[CB_CS2]   <= char_size_field[2];
            prdata[CB_RX9]   <= rx_ninth_bit;
          end
          OFF_CTRL_C: begin
            prdata[CC_PM1]        <= parity_check_enable;
            prdata[CC_PM0]        <= parity_odd_select;
            prdata[CC_STOP]       <= stop_bit_count_select;
            prdata[CC_CS_LO +: 2] <= char_size_field[1:0];
          end
          OFF_DATA: begin
            prdata[7:0] <= rx_complete_flag ? head.data : 8'h00;
          end
          OFF_BAUD: begin
            prdata[15:0] <= baud_div;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_rxc_on_store: assert property (rx_enable && push && !rd_pop |=> rx_complete_flag)
    else $error("Receive complete low after store");
  a_rxc_on_empty: assert property (rx_enable && rd_pop && count == 2'h1 && !push |=> !rx_complete_flag)
    else $error("Receive complete high on empty buffer");
  a_disable_flush: assert property (!rx_enable |=> !rx_complete_flag && !rx_complete_irq)
    else $error("Buffer not flushed on disable");
  a_irq_follows: assert property (
    rx_complete_irq_enable && global_irq_enable && $rose(rx_complete_flag) |-> rx_complete_irq)
    else $error("Receive interrupt missing");
  a_err_no_irq: assert property (!rx_complete_flag |-> !rx_complete_irq)
    else $error("Interrupt without receive data");
  a_status_wr_keep: assert property (
    wr && paddr == OFF_STATUS && count != 2'h0 && rx_enable
    |=> $stable({frame_error_flag, overrun_flag, head.pe}))
    else $error("Error flags changed by write");
  a_pop_frees: assert property (
    rx_enable && rd_pop && count == 2'h2 && !push |=> count == 2'h1)
    else $error("Read did not free a slot");
  a_ovr_set: assert property (ovr_start && rx_enable |=> dor_pend && !hold_valid)
    else $error("Overrun not recorded");
  a_ovr_clear: assert property (push && rx_enable && !ovr_start |=> !dor_pend)
    else $error("Overrun not cleared on transfer");
  a_pe_off: assert property (!parity_check_enable |-> !parity_error_flag)
    else $error("Parity error shown with checking off");

endmodule
